// >>> include/fault_seq_pkg.sv
package fault_seq_pkg;
    // Command codes
    localparam logic [7:0] CMD_INPUT_UV_FAULT_THRESHOLD = 8'h59;
    localparam logic [7:0] CMD_INPUT_UV_FAULT_ACTION = 8'h5A;
    localparam logic [7:0] CMD_POWER_GOOD_ON_THRESHOLD = 8'h5E;
    localparam logic [7:0] CMD_TURN_ON_DELAY = 8'h60;
    localparam logic [7:0] CMD_TURN_ON_RAMP_TIME = 8'h61;
    localparam logic [7:0] CMD_TURN_OFF_DELAY = 8'h64;
    localparam logic [7:0] CMD_TURN_OFF_RAMP_TIME = 8'h65;
    localparam logic [7:0] CMD_STATUS_SUMMARY_BYTE = 8'h78;
    localparam logic [7:0] CMD_STATUS_SUMMARY_WORD = 8'h79;

    // Reset values
    localparam logic [7:0] UV_ACTION_RESET = 8'h80;
    localparam logic [15:0] THRESHOLD_RESET = 16'h0000;
    localparam logic [15:0] TIME_RESET = 16'h0000;
    localparam logic [15:0] STATUS_RESET = 16'h0000;

    // Fault action fields
    localparam int ACTION_RSVD_HI = 7;
    localparam int ACTION_RSVD_LO = 6;
    localparam logic [1:0] ACTION_RSVD_VALUE = 2'h2;
    localparam int RETRY_MODE_HI = 5;
    localparam int RETRY_MODE_LO = 3;
    localparam int RETRY_DELAY_HI = 2;
    localparam int RETRY_DELAY_LO = 0;
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_CONTINUOUS = 3'h7;

    // Status bit positions
    localparam int ST_BUSY = 7;
    localparam int ST_OFF = 6;
    localparam int ST_VOUT_OV = 5;
    localparam int ST_IOUT_OC = 4;
    localparam int ST_VIN_UV = 3;
    localparam int ST_TEMP = 2;
    localparam int ST_COMM = 1;
    localparam int ST_NONE_ABOVE = 0;
    localparam int SW_VOUT = 7;
    localparam int SW_IOUT = 6;
    localparam int SW_INPUT = 5;
    localparam int SW_VENDOR = 4;
    localparam int SW_PG_N = 3;
    localparam int SW_FANS = 2;
    localparam int SW_OTHER = 1;
    localparam int SW_UNKNOWN = 0;

    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam logic [15:0] RETRY_STEP_MS = 16'd35;
    localparam logic [15:0] ON_DELAY_MIN_MS = 16'd2;
    localparam logic [15:0] ON_DELAY_MAX_MS = 16'd256;
    localparam logic [15:0] OFF_DELAY_MAX_MS = 16'd256;
    localparam logic [15:0] RAMP_MAX_MS = 16'd100;

    typedef struct packed {
        logic write;
        logic [7:0] code;
        logic [15:0] wdata;
    } cmd_t;

    typedef struct packed {
        logic vout_ov_fault;
        logic iout_oc_fault;
        logic temp_alert;
        logic comm_memory_logic_flag;
        logic other_warning;
        logic vout_flag;
        logic iout_flag;
        logic input_flag;
        logic vendor_specific_flag;
        logic fan_flag;
        logic other_status_flag;
        logic unknown_flag;
    } fault_in_t;

    typedef enum logic [2:0] {
        ST_OUT_OFF = 3'b000,
        ST_ON_WAIT = 3'b001,
        ST_RISING = 3'b010,
        ST_POWERED = 3'b011,
        ST_OFF_WAIT = 3'b100,
        ST_FALLING = 3'b101,
        ST_HELD = 3'b110,
        ST_RETRY = 3'b111
    } seq_state_t;
endpackage

// >>> rtl/fault_seq_status.sv
`timescale 1ns/1ps
module fault_seq_status #(
    parameter int MS_CYCLES = fault_seq_pkg::MS_CYCLES
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clk_link,
    input wire logic cmd_valid,
    input wire fault_seq_pkg::cmd_t cmd,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [15:0] rsp_rdata,
    output logic rsp_error,
    input wire logic enable_request,
    input wire logic [15:0] vin_level,
    input wire logic [15:0] vout_level,
    input wire logic [15:0] input_uv_warning_threshold,
    input wire logic [15:0] output_uv_warning_threshold,
    input wire logic [15:0] power_good_delay,
    input wire fault_seq_pkg::fault_in_t fault_in,
    output logic output_enable,
    output logic ramp_up,
    output logic ramp_down,
    output logic power_good
);
    function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
        logic [15:0] r;
        r = v;
        if (r < lo) begin
            r = lo;
        end
        if (r > hi) begin
            r = hi;
        end
        return r;
    endfunction

    // Link domain: reset, request capture, crossing
    logic rst_l1, rst_l2;
    logic pending, req_tog;
    logic busy_tog;
    fault_seq_pkg::cmd_t cmd_hold;
    logic ack_l1, ack_l2, ack_l3;
    logic ack_tog;
    logic [15:0] rdata_hold;
    logic err_hold;

    always_ff @(posedge clk_link) begin
        rst_l1 <= reset;
        rst_l2 <= rst_l1;
    end

    assign cmd_ready = ~pending;

    always_ff @(posedge clk_link) begin
        if (rst_l2) begin
            pending <= 1'b0;
            req_tog <= 1'b0;
            busy_tog <= 1'b0;
            cmd_hold <= '0;
        end else begin
            if (cmd_valid && !pending) begin
                pending <= 1'b1;
                req_tog <= ~req_tog;
                cmd_hold <= cmd;
            end else if (ack_l3 != ack_l2) begin
                pending <= 1'b0;
            end
            if (cmd_valid && pending) begin
                busy_tog <= ~busy_tog;
            end
        end
    end

    always_ff @(posedge clk_link) begin
        if (rst_l2) begin
            ack_l1 <= 1'b0;
            ack_l2 <= 1'b0;
            ack_l3 <= 1'b0;
        end else begin
            ack_l1 <= ack_tog;
            ack_l2 <= ack_l1;
            ack_l3 <= ack_l2;
        end
    end

    always_ff @(posedge clk_link) begin
        if (rst_l2) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= 16'h0000;
            rsp_error <= 1'b0;
        end else begin
            rsp_valid <= ack_l3 != ack_l2;
            if (ack_l3 != ack_l2) begin
                rsp_rdata <= rdata_hold;
                rsp_error <= err_hold;
            end
        end
    end

    // System domain: synchronisers
    logic req_s1, req_s2, req_s3;
    logic busy_s1, busy_s2, busy_s3;
    logic [15:0] vin_s1, vin_s, vout_s1, vout_s;
    logic en_s1, en_s;
    fault_seq_pkg::fault_in_t flt_s1, flt_s;

    always_ff @(posedge clk_sys) begin
        req_s1 <= req_tog;
        req_s2 <= req_s1;
        req_s3 <= req_s2;
        busy_s1 <= busy_tog;
        busy_s2 <= busy_s1;
        busy_s3 <= busy_s2;
        vin_s1 <= vin_level;
        vin_s <= vin_s1;
        vout_s1 <= vout_level;
        vout_s <= vout_s1;
        en_s1 <= enable_request;
        en_s <= en_s1;
        flt_s1 <= fault_in;
        flt_s <= flt_s1;
    end

    // Command registers
    logic [15:0] uv_threshold, pg_on_threshold;
    logic [15:0] on_delay_reg, on_ramp_reg, off_delay_reg, off_ramp_reg;
    logic [7:0] uv_action;
    logic [7:0] status_low;
    logic [7:0] status_high;
    logic comm_error;
    wire logic new_req = req_s3 != req_s2;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            uv_threshold <= fault_seq_pkg::THRESHOLD_RESET;
            pg_on_threshold <= fault_seq_pkg::THRESHOLD_RESET;
            on_delay_reg <= fault_seq_pkg::TIME_RESET;
            on_ramp_reg <= fault_seq_pkg::TIME_RESET;
            off_delay_reg <= fault_seq_pkg::TIME_RESET;
            off_ramp_reg <= fault_seq_pkg::TIME_RESET;
            uv_action <= fault_seq_pkg::UV_ACTION_RESET;
        end else if (new_req && cmd_hold.write) begin
            case (cmd_hold.code)
                fault_seq_pkg::CMD_INPUT_UV_FAULT_THRESHOLD: uv_threshold <= cmd_hold.wdata;
                fault_seq_pkg::CMD_INPUT_UV_FAULT_ACTION: begin
                    uv_action <= {fault_seq_pkg::ACTION_RSVD_VALUE, cmd_hold.wdata[5:0]};
                end
                fault_seq_pkg::CMD_POWER_GOOD_ON_THRESHOLD: pg_on_threshold <= cmd_hold.wdata;
                fault_seq_pkg::CMD_TURN_ON_DELAY: on_delay_reg <= cmd_hold.wdata;
                fault_seq_pkg::CMD_TURN_ON_RAMP_TIME: on_ramp_reg <= cmd_hold.wdata;
                fault_seq_pkg::CMD_TURN_OFF_DELAY: off_delay_reg <= cmd_hold.wdata;
                fault_seq_pkg::CMD_TURN_OFF_RAMP_TIME: off_ramp_reg <= cmd_hold.wdata;
                default: begin
                end
            endcase
        end
    end

    // Read answer and command error
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdata_hold <= 16'h0000;
            err_hold <= 1'b0;
            ack_tog <= 1'b0;
        end else if (new_req) begin
            ack_tog <= ~ack_tog;
            err_hold <= 1'b0;
            rdata_hold <= 16'h0000;
            case (cmd_hold.code)
                fault_seq_pkg::CMD_INPUT_UV_FAULT_THRESHOLD: rdata_hold <= uv_threshold;
                fault_seq_pkg::CMD_INPUT_UV_FAULT_ACTION: rdata_hold <= {8'h00, uv_action};
                fault_seq_pkg::CMD_POWER_GOOD_ON_THRESHOLD: rdata_hold <= pg_on_threshold;
                fault_seq_pkg::CMD_TURN_ON_DELAY: rdata_hold <= on_delay_reg;
                fault_seq_pkg::CMD_TURN_ON_RAMP_TIME: rdata_hold <= on_ramp_reg;
                fault_seq_pkg::CMD_TURN_OFF_DELAY: rdata_hold <= off_delay_reg;
                fault_seq_pkg::CMD_TURN_OFF_RAMP_TIME: rdata_hold <= off_ramp_reg;
                fault_seq_pkg::CMD_STATUS_SUMMARY_BYTE: begin
                    rdata_hold <= {8'h00, status_low};
                    err_hold <= cmd_hold.write;
                end
                fault_seq_pkg::CMD_STATUS_SUMMARY_WORD: begin
                    rdata_hold <= {status_high, status_low};
                    err_hold <= cmd_hold.write;
                end
                default: err_hold <= 1'b1;
            endcase
        end
    end

    // Sticky busy and communication errors; cleared only by reset
    logic busy_flag;
    wire logic bad_cmd = new_req && (cmd_hold.write
        ? (cmd_hold.code == fault_seq_pkg::CMD_STATUS_SUMMARY_BYTE
           || cmd_hold.code == fault_seq_pkg::CMD_STATUS_SUMMARY_WORD)
        : 1'b0);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            busy_flag <= 1'b0;
            comm_error <= 1'b0;
        end else begin
            if (busy_s3 != busy_s2) begin
                busy_flag <= 1'b1;
            end
            if (bad_cmd || (new_req && !(cmd_hold.code inside {
                    fault_seq_pkg::CMD_INPUT_UV_FAULT_THRESHOLD,
                    fault_seq_pkg::CMD_INPUT_UV_FAULT_ACTION,
                    fault_seq_pkg::CMD_POWER_GOOD_ON_THRESHOLD,
                    fault_seq_pkg::CMD_TURN_ON_DELAY, fault_seq_pkg::CMD_TURN_ON_RAMP_TIME,
                    fault_seq_pkg::CMD_TURN_OFF_DELAY, fault_seq_pkg::CMD_TURN_OFF_RAMP_TIME,
                    fault_seq_pkg::CMD_STATUS_SUMMARY_BYTE,
                    fault_seq_pkg::CMD_STATUS_SUMMARY_WORD}))) begin
                comm_error <= 1'b1;
            end
        end
    end

    // Millisecond tick
    logic [31:0] ms_count;
    logic ms_tick;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ms_count <= 32'h0000_0000;
            ms_tick <= 1'b0;
        end else if (ms_count == 32'(MS_CYCLES - 1)) begin
            ms_count <= 32'h0000_0000;
            ms_tick <= 1'b1;
        end else begin
            ms_count <= ms_count + 32'h0000_0001;
            ms_tick <= 1'b0;
        end
    end

    // Input undervoltage fault with hysteresis
    logic uv_fault;
    wire logic uv_below = vin_s < uv_threshold;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            uv_fault <= 1'b0;
        end else if (uv_below) begin
            uv_fault <= 1'b1;
        end else if (vin_s > input_uv_warning_threshold) begin
            uv_fault <= 1'b0;
        end
    end

    // Sequencer
    fault_seq_pkg::seq_state_t state, next_state;
    logic [15:0] tmr, target;
    logic shut_latched;
    wire logic other_shut = flt_s.vout_ov_fault | flt_s.iout_oc_fault;
    wire logic [2:0] retry_mode = uv_action[fault_seq_pkg::RETRY_MODE_HI:fault_seq_pkg::RETRY_MODE_LO];
    wire logic [2:0] retry_code = uv_action[fault_seq_pkg::RETRY_DELAY_HI:fault_seq_pkg::RETRY_DELAY_LO];
    wire logic timer_done = tmr >= target;
    wire logic live = state inside {fault_seq_pkg::ST_RISING,
                                    fault_seq_pkg::ST_POWERED, fault_seq_pkg::ST_OFF_WAIT,
                                    fault_seq_pkg::ST_FALLING};

    always_comb begin
        case (state)
            fault_seq_pkg::ST_ON_WAIT: target = clamp(on_delay_reg,
                fault_seq_pkg::ON_DELAY_MIN_MS, fault_seq_pkg::ON_DELAY_MAX_MS);
            fault_seq_pkg::ST_RISING: target = clamp(on_ramp_reg, 16'h0000,
                fault_seq_pkg::RAMP_MAX_MS);
            fault_seq_pkg::ST_OFF_WAIT: target = clamp(off_delay_reg, 16'h0000,
                fault_seq_pkg::OFF_DELAY_MAX_MS);
            fault_seq_pkg::ST_FALLING: target = clamp(off_ramp_reg, 16'h0000,
                fault_seq_pkg::RAMP_MAX_MS);
            fault_seq_pkg::ST_RETRY: target = 16'({13'h0000, retry_code} + 16'h0001)
                * fault_seq_pkg::RETRY_STEP_MS;
            default: target = 16'h0000;
        endcase
    end

    always_comb begin
        next_state = state;
        case (state)
            fault_seq_pkg::ST_OUT_OFF: begin
                if (en_s && !uv_fault) begin
                    next_state = fault_seq_pkg::ST_ON_WAIT;
                end
            end
            fault_seq_pkg::ST_ON_WAIT: begin
                if (!en_s) begin
                    next_state = fault_seq_pkg::ST_OUT_OFF;
                end else if (timer_done) begin
                    next_state = fault_seq_pkg::ST_RISING;
                end
            end
            fault_seq_pkg::ST_RISING: begin
                if (!en_s) begin
                    next_state = fault_seq_pkg::ST_OFF_WAIT;
                end else if (timer_done) begin
                    next_state = fault_seq_pkg::ST_POWERED;
                end
            end
            fault_seq_pkg::ST_POWERED: begin
                if (!en_s) begin
                    next_state = fault_seq_pkg::ST_OFF_WAIT;
                end
            end
            fault_seq_pkg::ST_OFF_WAIT: begin
                if (timer_done) begin
                    next_state = fault_seq_pkg::ST_FALLING;
                end
            end
            fault_seq_pkg::ST_FALLING: begin
                if (timer_done) begin
                    next_state = fault_seq_pkg::ST_OUT_OFF;
                end
            end
            fault_seq_pkg::ST_HELD: begin
                if (!en_s) begin
                    next_state = fault_seq_pkg::ST_OUT_OFF;
                end else if (!shut_latched && !uv_fault) begin
                    next_state = fault_seq_pkg::ST_ON_WAIT;
                end
            end
            fault_seq_pkg::ST_RETRY: begin
                if (!en_s) begin
                    next_state = fault_seq_pkg::ST_OUT_OFF;
                end else if (timer_done) begin
                    next_state = fault_seq_pkg::ST_ON_WAIT;
                end
            end
            default: next_state = fault_seq_pkg::ST_OUT_OFF;
        endcase
        if (other_shut && state != fault_seq_pkg::ST_OUT_OFF) begin
            next_state = fault_seq_pkg::ST_HELD;
        end else if (uv_below && live) begin
            next_state = (retry_mode == fault_seq_pkg::RETRY_CONTINUOUS)
                ? fault_seq_pkg::ST_RETRY : fault_seq_pkg::ST_HELD;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state <= fault_seq_pkg::ST_OUT_OFF;
            tmr <= 16'h0000;
        end else begin
            state <= next_state;
            if (next_state != state) begin
                tmr <= 16'h0000;
            end else if (ms_tick && !timer_done) begin
                tmr <= tmr + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            shut_latched <= 1'b0;
        end else if (other_shut && state != fault_seq_pkg::ST_OUT_OFF) begin
            shut_latched <= 1'b1;
        end else if (!en_s) begin
            shut_latched <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            output_enable <= 1'b0;
            ramp_up <= 1'b0;
            ramp_down <= 1'b0;
        end else begin
            output_enable <= next_state inside {fault_seq_pkg::ST_RISING,
                fault_seq_pkg::ST_POWERED, fault_seq_pkg::ST_OFF_WAIT, fault_seq_pkg::ST_FALLING};
            ramp_up <= next_state == fault_seq_pkg::ST_RISING;
            ramp_down <= next_state == fault_seq_pkg::ST_FALLING;
        end
    end

    // Power good
    logic [15:0] pg_tmr;
    logic pg_armed;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            power_good <= 1'b0;
            pg_armed <= 1'b0;
            pg_tmr <= 16'h0000;
        end else if (vout_s < output_uv_warning_threshold || !output_enable) begin
            power_good <= 1'b0;
            pg_armed <= 1'b0;
            pg_tmr <= 16'h0000;
        end else if (!pg_armed) begin
            pg_armed <= vout_s > pg_on_threshold;
            pg_tmr <= 16'h0000;
        end else if (pg_tmr >= power_good_delay) begin
            power_good <= 1'b1;
        end else if (ms_tick) begin
            pg_tmr <= pg_tmr + 16'h0001;
        end
    end

    // Status summary; one storage for byte and word low half
    logic uv_warn;
    assign uv_warn = vin_s < input_uv_warning_threshold;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            status_low <= fault_seq_pkg::STATUS_RESET[7:0];
            status_high <= fault_seq_pkg::STATUS_RESET[15:8];
        end else begin
            status_low[fault_seq_pkg::ST_BUSY] <= busy_flag;
            status_low[fault_seq_pkg::ST_OFF] <= ~output_enable;
            status_low[fault_seq_pkg::ST_VOUT_OV] <= flt_s.vout_ov_fault;
            status_low[fault_seq_pkg::ST_IOUT_OC] <= flt_s.iout_oc_fault;
            status_low[fault_seq_pkg::ST_VIN_UV] <= uv_fault;
            status_low[fault_seq_pkg::ST_TEMP] <= flt_s.temp_alert;
            status_low[fault_seq_pkg::ST_COMM] <= flt_s.comm_memory_logic_flag | comm_error;
            status_low[fault_seq_pkg::ST_NONE_ABOVE] <= flt_s.other_warning | uv_warn;
            status_high[fault_seq_pkg::SW_VOUT] <= flt_s.vout_flag | flt_s.vout_ov_fault;
            status_high[fault_seq_pkg::SW_IOUT] <= flt_s.iout_flag | flt_s.iout_oc_fault;
            status_high[fault_seq_pkg::SW_INPUT] <= flt_s.input_flag | uv_fault | uv_warn;
            status_high[fault_seq_pkg::SW_VENDOR] <= flt_s.vendor_specific_flag;
            status_high[fault_seq_pkg::SW_PG_N] <= ~power_good;
            status_high[fault_seq_pkg::SW_FANS] <= flt_s.fan_flag;
            status_high[fault_seq_pkg::SW_OTHER] <= flt_s.other_status_flag;
            status_high[fault_seq_pkg::SW_UNKNOWN] <= flt_s.unknown_flag;
        end
    end
endmodule // fault_seq_status

// >>> tb/fault_seq_checker.sv
`timescale 1ns/1ps
module fault_seq_checker #(
    parameter int MS_CYCLES = 20
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clk_link,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    input wire logic enable_request,
    input wire logic [15:0] vout_level,
    input wire logic [15:0] output_uv_warning_threshold,
    input wire logic output_enable,
    input wire logic ramp_up,
    input wire logic ramp_down,
    input wire logic power_good
);
    logic [31:0] en_cnt;
    // Cycles since enable was requested
    always_ff @(posedge clk_sys) begin
        if (reset || !enable_request) begin
            en_cnt <= '0;
        end else begin
            en_cnt <= en_cnt + 32'd1;
        end
    end
    sequence s_take;
        cmd_valid && cmd_ready;
    endsequence
    sequence s_vout_low;
        (vout_level < output_uv_warning_threshold) [*6];
    endsequence
    a_ready_drops: assert property (@(posedge clk_link) disable iff (reset)
        s_take |=> !cmd_ready) else $error("ready stayed high after take");
    a_answer_bound: assert property (@(posedge clk_link) disable iff (reset)
        s_take |-> ##[1:40] rsp_valid) else $error("no answer in time");
    a_rsp_single: assert property (@(posedge clk_link) disable iff (reset)
        rsp_valid |=> !rsp_valid && cmd_ready) else $error("answer pulse wrong");
    a_ramp_excl: assert property (@(posedge clk_sys) disable iff (reset)
        !(ramp_up && ramp_down)) else $error("both ramps active");
    a_ramp_powered: assert property (@(posedge clk_sys) disable iff (reset)
        ramp_up || ramp_down |-> output_enable) else $error("ramp without output");
    a_on_delay_min: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(output_enable) |-> en_cnt >= MS_CYCLES) else $error("turn-on too early");
    a_pg_drop: assert property (@(posedge clk_sys) disable iff (reset)
        s_vout_low |-> !power_good) else $error("power good held below limit");
    a_pg_off_out: assert property (@(posedge clk_sys) disable iff (reset)
        !output_enable [*2] |-> !power_good) else $error("power good while off");
    a_pg_rise: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(power_good) |-> $past(output_enable)) else $error("power good before output");
endmodule // fault_seq_checker

bind fault_seq_status fault_seq_checker #(.MS_CYCLES(MS_CYCLES)) fault_seq_checker_i (
    .clk_sys, .reset, .clk_link, .cmd_valid, .cmd_ready, .rsp_valid, .enable_request,
    .vout_level, .output_uv_warning_threshold, .output_enable, .ramp_up, .ramp_down,
    .power_good);

// >>> tb/host_model.sv
`timescale 1ns/1ps
module host_model (
    input wire logic clk_link,
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    input wire logic [15:0] rsp_rdata,
    input wire logic rsp_error,
    output logic cmd_valid,
    output fault_seq_pkg::cmd_t cmd
);
    initial cmd_valid = 1'b0;
    initial cmd = '0;
    // One command held until taken; extra holds it one more cycle
    task automatic xfer(input fault_seq_pkg::cmd_t c, input bit extra,
            output logic [15:0] rd, output logic er, output bit hung);
        int n;
        n = 0;
        @(posedge clk_link);
        while (!cmd_ready && n < 60) begin
            @(posedge clk_link);
            n++;
        end
        cmd_valid <= 1'b1;
        cmd <= c;
        @(posedge clk_link);
        if (extra) begin
            @(posedge clk_link);
        end
        cmd_valid <= 1'b0;
        cmd <= ~c;
        while (!rsp_valid && n < 60) begin
            @(posedge clk_link);
            n++;
        end
        rd = rsp_rdata;
        er = rsp_error;
        hung = (n >= 60);
    endtask
endmodule // host_model

// >>> tb/test_fault_seq_status.sv
`timescale 1ns/1ps
module test_fault_seq_status;
    typedef struct {logic wr; logic [7:0] code; logic [15:0] wd; logic [15:0] exp; logic err;} row_t;
    logic clk_sys = 1'b0, clk_link = 1'b0, reset = 1'b1, enable_request = 1'b0;
    logic cmd_valid, cmd_ready, rsp_valid, rsp_error, output_enable, ramp_up, ramp_down;
    logic power_good, er;
    logic [15:0] rsp_rdata, rd, vin_level = 16'h0200, vout_level = 16'h0200;
    logic [15:0] power_good_delay = 16'h0001;
    fault_seq_pkg::cmd_t cmd;
    fault_seq_pkg::fault_in_t fault_in = '0;
    bit hung;
    int n_fail = 0, n_tests = 0, n;
    row_t rows[13] = '{
        '{0, 8'h5A, 16'h0000, 16'h0080, 0},
        '{0, 8'h78, 16'h0000, 16'h0040, 0},
        '{0, 8'h79, 16'h0000, 16'h0840, 0},
        '{1, 8'h59, 16'h0100, 16'h0000, 0},
        '{1, 8'h5A, 16'h0007, 16'h0080, 0},
        '{0, 8'h5A, 16'h0000, 16'h0087, 0},
        '{1, 8'h60, 16'h0002, 16'h0000, 0},
        '{1, 8'h61, 16'h0002, 16'h0000, 0},
        '{0, 8'h33, 16'h0000, 16'h0000, 1},
        '{1, 8'h78, 16'h0055, 16'h0042, 1},
        '{0, 8'h79, 16'h0000, 16'h0842, 0},
        '{1, 8'h64, 16'h0002, 16'h0000, 0},
        '{1, 8'h65, 16'h0002, 16'h0000, 0}};
    always #10 clk_sys = ~clk_sys;
    always #3 clk_link = ~clk_link;
    fault_seq_status #(.MS_CYCLES(20)) fault_seq_status_i (
        .clk_sys, .reset, .clk_link, .cmd_valid, .cmd, .cmd_ready, .rsp_valid, .rsp_rdata,
        .rsp_error, .enable_request, .vin_level, .vout_level,
        .input_uv_warning_threshold(16'h0180), .output_uv_warning_threshold(16'h00C0),
        .power_good_delay, .fault_in, .output_enable, .ramp_up, .ramp_down, .power_good);
    host_model host_model_i (
        .clk_link, .cmd_ready, .rsp_valid, .rsp_rdata, .rsp_error, .cmd_valid, .cmd);
    task automatic stop_test();
        if (n_fail == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic run(input logic wr, input logic [7:0] c, input logic [15:0] wd, input bit x);
        host_model_i.xfer('{write: wr, code: c, wdata: wd}, x, rd, er, hung);
        if (hung) begin
            n_fail++;
            stop_test();
        end
    endtask
    task automatic wait_for(ref logic s, input logic v, input int lim);
        n = 0;
        while (s !== v) begin
            @(posedge clk_sys);
            n++;
            if (n > lim) begin
                n_fail++;
                stop_test();
            end
        end
    endtask
    initial begin
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (4) @(posedge clk_sys);
        foreach (rows[i]) begin
            run(rows[i].wr, rows[i].code, rows[i].wd, 0);
            check(rd, rows[i].exp);
            check({15'h0, er}, {15'h0, rows[i].err});
        end
        // Second request while busy is dropped
        run(0, 8'h78, 16'h0000, 1);
        @(posedge clk_sys);
        fault_in.temp_alert <= 1'b1;
        repeat (6) @(posedge clk_sys);
        run(0, 8'h78, 16'h0000, 0);
        check({14'h0, rd[7], rd[2]}, 16'h0003);
        @(posedge clk_sys);
        enable_request <= 1'b1;
        wait_for(output_enable, 1, 200);
        check({15'h0, n >= 20}, 16'h0001);
        check({15'h0, ramp_up}, 16'h0001);
        wait_for(power_good, 1, 400);
        vout_level <= 16'h0080;
        wait_for(power_good, 0, 8);
        run(0, 8'h79, 16'h0000, 0);
        check({15'h0, rd[11]}, 16'h0001);
        @(posedge clk_sys);
        vout_level <= 16'h0200;
        vin_level <= 16'h00F0;
        wait_for(output_enable, 0, 10);
        run(0, 8'h79, 16'h0000, 0);
        check({14'h0, rd[13], rd[3]}, 16'h0003);
        @(posedge clk_sys);
        vin_level <= 16'h0150;
        repeat (200) @(posedge clk_sys);
        check({15'h0, output_enable}, 16'h0000);
        vin_level <= 16'h0200;
        wait_for(output_enable, 1, 200);
        run(1, 8'h5A, 16'h0038, 0);
        @(posedge clk_sys);
        vin_level <= 16'h00F0;
        wait_for(output_enable, 0, 10);
        wait_for(output_enable, 1, 1000);
        check({15'h0, n >= 680}, 16'h0001);
        // Turn-off path through off-delay and fall
        vin_level <= 16'h0200;
        wait_for(power_good, 1, 1000);
        enable_request <= 1'b0;
        wait_for(ramp_down, 1, 100);
        check({15'h0, n >= 20}, 16'h0001);
        check({15'h0, output_enable}, 16'h0001);
        wait_for(output_enable, 0, 100);
        check({15'h0, ramp_down}, 16'h0000);
        // Every external flag reaches its summary bit
        fault_in <= '1;
        repeat (4) @(posedge clk_sys);
        run(0, 8'h79, 16'h0000, 0);
        check(rd, 16'hFFF7);
        stop_test();
    end
endmodule // test_fault_seq_status
